/* File: src/tmrm_pkg.sv */
package tmrm_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_INT_TEMP = 8'h00;
   localparam logic [7:0] OFS_EXT1_TEMP = 8'h01;
   localparam logic [7:0] OFS_STATUS = 8'h02;
   localparam logic [7:0] OFS_CTRL = 8'h03;
   localparam logic [7:0] OFS_PACING = 8'h04;
   localparam logic [7:0] OFS_INT_HI = 8'h05;
   localparam logic [7:0] OFS_INT_LO = 8'h06;
   localparam logic [7:0] OFS_EXT1_HI = 8'h07;
   localparam logic [7:0] OFS_EXT1_LO = 8'h08;
   localparam logic [7:0] OFS_CTRL_ALIAS = 8'h09;
   localparam logic [7:0] OFS_PACING_ALIAS = 8'h0A;
   localparam logic [7:0] OFS_INT_HI_ALIAS = 8'h0B;
   localparam logic [7:0] OFS_INT_LO_ALIAS = 8'h0C;
   localparam logic [7:0] OFS_EXT1_HI_ALIAS = 8'h0D;
   localparam logic [7:0] OFS_EXT1_LO_ALIAS = 8'h0E;
   localparam logic [7:0] OFS_ONESHOT = 8'h0F;
   localparam logic [7:0] OFS_EXT1_FRAC = 8'h10;
   localparam logic [7:0] OFS_SPARE_A = 8'h11;
   localparam logic [7:0] OFS_SPARE_B = 8'h12;
   localparam logic [7:0] OFS_EXT1_HI_FRAC = 8'h13;
   localparam logic [7:0] OFS_EXT1_LO_FRAC = 8'h14;
   localparam logic [7:0] OFS_EXT2_HI = 8'h15;
   localparam logic [7:0] OFS_EXT2_LO = 8'h16;
   localparam logic [7:0] OFS_EXT2_HI_FRAC = 8'h17;
   localparam logic [7:0] OFS_EXT2_LO_FRAC = 8'h18;
   localparam logic [7:0] OFS_EXT1_CRIT = 8'h19;
   localparam logic [7:0] OFS_EXT2_CRIT = 8'h1A;
   localparam logic [7:0] OFS_FAULT = 8'h1B;
   localparam logic [7:0] OFS_CHAN_MASK = 8'h1F;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h80;
   localparam logic [7:0] RST_PACING = 8'h06;
   localparam logic [7:0] RST_LIMIT_85 = 8'h55;
   localparam logic [10:0] RST_TEMP = 11'h000;

   // ==========================================================
   // Field layouts
   localparam int CTRL_EXT_RANGE_BIT = 2;
   localparam int FAULT_EXT1_BIT = 1;
   localparam int FAULT_EXT2_BIT = 2;
   localparam logic [7:0] FAULT_USED = 8'h06;
   localparam logic [7:0] MASK_USED = 8'h07;
   localparam logic [7:0] FRAC_USED = 8'hE0;
   localparam logic [11:0] EXT_OFFSET = 12'h200;
   localparam logic [11:0] DEF_MAX = 12'h3FF;
   localparam logic [11:0] EXT_MAX = 12'h7FF;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [0:0] {
      TMRM_LNK_IDLE = 1'b0,
      TMRM_LNK_BUSY = 1'b1
   } tmrm_lnk_state_t;
endpackage

/* File: src/tmrm_regs.sv */
// Summary of operation
// RQ1 - Unused register bits always read zero
// RQ2 - All access goes through the serial port
// RQ3 - Control byte shared at 03h/09h, reset 80h
// RQ4 - Pacing byte shared at 04h/0Ah, reset 06h
// RQ5 - Internal upper limit at 05h/0Bh, reset 55h
// RQ6 - Internal lower limit at 06h/0Ch, reset 00h
// RQ7 - Ext1 upper limit 07h/0Dh plus fraction 13h
// RQ8 - Ext1 lower limit 08h/0Eh plus fraction 14h
// RQ9 - Any write to 0Fh starts one conversion
// RQ10 - Ext1 result read-only at 01h and 10h
// RQ11 - Internal result read-only at 00h
// RQ12 - Read-only status summary at 02h
// RQ13 - Two scratch bytes at 11h, 12h
// RQ14 - Ext2 limits at 15h through 18h
// RQ15 - Ext1/ext2 critical limits at 19h, 1Ah
// RQ16 - Fault flags at 1Bh clear on read
// RQ17 - Channel mask byte at 1Fh, reset 00h
// RQ18 - Results eleven bits, high/low byte split; internal result reads as high byte only at 00h
// RQ19 - Extended range adds a 64 degree offset
// RQ20 - Writes to read-only ignored, 0Fh reads zero
module tmrm_regs (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic lnk_clk_i,
   input wire logic lnk_req_i,
   input wire logic lnk_wr_i,
   input wire logic [7:0] lnk_addr_i,
   input wire logic [7:0] lnk_wdata_i,
   output logic lnk_busy_o,
   output logic lnk_ack_o,
   output logic [7:0] lnk_rdata_o,
   input wire logic meas_valid_i,
   input wire logic [11:0] int_temp_i,
   input wire logic [11:0] ext1_temp_i,
   input wire logic ext1_fault_i,
   input wire logic ext2_fault_i,
   input wire logic [7:0] status_i,
   output logic [7:0] ctrl_o,
   output logic [7:0] pacing_o,
   output logic ext_range_o,
   output logic oneshot_o,
   output logic [7:0] int_hi_lim_o,
   output logic [7:0] int_lo_lim_o,
   output logic [10:0] ext1_hi_lim_o,
   output logic [10:0] ext1_lo_lim_o,
   output logic [10:0] ext2_hi_lim_o,
   output logic [10:0] ext2_lo_lim_o,
   output logic [7:0] ext1_crit_o,
   output logic [7:0] ext2_crit_o,
   output logic [7:0] chan_mask_o
);
   // ==========================================================
   // Helper functions
   function automatic logic [7:0] canon(input logic [7:0] a);
      begin
         if (a == tmrm_pkg::OFS_CTRL_ALIAS) begin
            canon = tmrm_pkg::OFS_CTRL;
         end else if (a == tmrm_pkg::OFS_PACING_ALIAS) begin
            canon = tmrm_pkg::OFS_PACING;
         end else if (a == tmrm_pkg::OFS_INT_HI_ALIAS) begin
            canon = tmrm_pkg::OFS_INT_HI;
         end else if (a == tmrm_pkg::OFS_INT_LO_ALIAS) begin
            canon = tmrm_pkg::OFS_INT_LO;
         end else if (a == tmrm_pkg::OFS_EXT1_HI_ALIAS) begin
            canon = tmrm_pkg::OFS_EXT1_HI;
         end else if (a == tmrm_pkg::OFS_EXT1_LO_ALIAS) begin
            canon = tmrm_pkg::OFS_EXT1_LO;
         end else begin
            canon = a;
         end
      end
   endfunction

   // Signed eighths of a degree to 11-bit result code, clamped
   function automatic logic [10:0] encode(input logic [11:0] t, input logic ext);
      logic [11:0] v;
      logic [11:0] lim;
      begin
         v = ext ? 12'(t + tmrm_pkg::EXT_OFFSET) : t;
         lim = ext ? tmrm_pkg::EXT_MAX : tmrm_pkg::DEF_MAX;
         if (ext && t[11] && v[11]) begin
            encode = 11'h000;
         end else if (ext && !t[11] && v[11]) begin
            encode = 11'h7FF;
         end else if (!ext && t[11]) begin
            encode = 11'h000;
         end else if (v > lim) begin
            encode = lim[10:0];
         end else begin
            encode = v[10:0];
         end
      end
   endfunction

   // ==========================================================
   // Link domain: reset sync and request capture
   logic lrst_s1_ff, lrst_s2_ff;
   tmrm_pkg::tmrm_lnk_state_t lst_ff, nxt_lst;
   logic req_tgl_ff, lwr_ff;
   logic [7:0] laddr_ff, lwdata_ff, lrdata_ff;
   logic ack_s1_ff, ack_s2_ff, ack_s3_ff;
   logic lack_ff;
   logic ack_tgl_ff;
   logic [7:0] crdata_ff;

   always_ff @(posedge lnk_clk_i) begin
      lrst_s1_ff <= rst_i;
      lrst_s2_ff <= lrst_s1_ff;
   end

   wire lnk_take = (lst_ff == tmrm_pkg::TMRM_LNK_IDLE) && lnk_req_i; // RQ2
   wire lnk_done = ack_s2_ff ^ ack_s3_ff;

   always_comb begin
      nxt_lst = lst_ff;
      case (lst_ff)
         tmrm_pkg::TMRM_LNK_IDLE: begin
            if (lnk_req_i) begin
               nxt_lst = tmrm_pkg::TMRM_LNK_BUSY;
            end
         end
         tmrm_pkg::TMRM_LNK_BUSY: begin
            if (lnk_done) begin
               nxt_lst = tmrm_pkg::TMRM_LNK_IDLE;
            end
         end
         default: nxt_lst = tmrm_pkg::TMRM_LNK_IDLE;
      endcase
   end

   always_ff @(posedge lnk_clk_i) begin
      if (lrst_s2_ff) begin
         lst_ff <= tmrm_pkg::TMRM_LNK_IDLE;
         req_tgl_ff <= 1'b0;
         lwr_ff <= 1'b0;
         laddr_ff <= tmrm_pkg::RST_ZERO;
         lwdata_ff <= tmrm_pkg::RST_ZERO;
      end else begin
         lst_ff <= nxt_lst;
         if (lnk_take) begin
            req_tgl_ff <= ~req_tgl_ff;
            lwr_ff <= lnk_wr_i;
            laddr_ff <= lnk_addr_i;
            lwdata_ff <= lnk_wdata_i;
         end
      end
   end

   always_ff @(posedge lnk_clk_i) begin
      if (lrst_s2_ff) begin
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
         ack_s3_ff <= 1'b0;
         lack_ff <= 1'b0;
         lrdata_ff <= tmrm_pkg::RST_ZERO;
      end else begin
         ack_s1_ff <= ack_tgl_ff;
         ack_s2_ff <= ack_s1_ff;
         ack_s3_ff <= ack_s2_ff;
         lack_ff <= lnk_done;
         if (lnk_done) begin
            lrdata_ff <= crdata_ff;
         end
      end
   end

   assign lnk_busy_o = (lst_ff == tmrm_pkg::TMRM_LNK_BUSY);
   assign lnk_ack_o = lack_ff;
   assign lnk_rdata_o = lrdata_ff;

   // ==========================================================
   // Core domain: request detection
   logic req_s1_ff, req_s2_ff, req_s3_ff;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         req_s1_ff <= 1'b0;
         req_s2_ff <= 1'b0;
         req_s3_ff <= 1'b0;
      end else begin
         req_s1_ff <= req_tgl_ff;
         req_s2_ff <= req_s1_ff;
         req_s3_ff <= req_s2_ff;
      end
   end

   // Address and data are held by the link side until the answer returns
   wire acc = req_s2_ff ^ req_s3_ff;
   wire [7:0] cadr = canon(laddr_ff);
   wire wr_en = acc && lwr_ff;
   wire rd_en = acc && !lwr_ff;

   // ==========================================================
   // Core domain: storage
   logic [7:0] ctrl_ff, pacing_ff, int_hi_ff, int_lo_ff;
   logic [7:0] e1_hi_ff, e1_lo_ff, e1_hif_ff, e1_lof_ff;
   logic [7:0] e2_hi_ff, e2_lo_ff, e2_hif_ff, e2_lof_ff;
   logic [7:0] e1_crit_ff, e2_crit_ff, spare_a_ff, spare_b_ff;
   logic [7:0] mask_ff, fault_ff, status_ff;
   logic [10:0] int_res_ff, e1_res_ff;
   logic oneshot_ff;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ctrl_ff <= tmrm_pkg::RST_CTRL; // RQ3
         pacing_ff <= tmrm_pkg::RST_PACING; // RQ4
         int_hi_ff <= tmrm_pkg::RST_LIMIT_85; // RQ5
         int_lo_ff <= tmrm_pkg::RST_ZERO; // RQ6
         e1_hi_ff <= tmrm_pkg::RST_LIMIT_85; // RQ7
         e1_hif_ff <= tmrm_pkg::RST_ZERO;
         e1_lo_ff <= tmrm_pkg::RST_ZERO; // RQ8
         e1_lof_ff <= tmrm_pkg::RST_ZERO;
         spare_a_ff <= tmrm_pkg::RST_ZERO; // RQ13
         spare_b_ff <= tmrm_pkg::RST_ZERO;
         e2_hi_ff <= tmrm_pkg::RST_LIMIT_85; // RQ14
         e2_lo_ff <= tmrm_pkg::RST_ZERO;
         e2_hif_ff <= tmrm_pkg::RST_ZERO;
         e2_lof_ff <= tmrm_pkg::RST_ZERO;
         e1_crit_ff <= tmrm_pkg::RST_LIMIT_85; // RQ15
         e2_crit_ff <= tmrm_pkg::RST_LIMIT_85;
         mask_ff <= tmrm_pkg::RST_ZERO; // RQ17
      end else if (wr_en) begin
         // Read-only, read-clear and unmapped addresses fall through
         if (cadr == tmrm_pkg::OFS_CTRL) begin
            ctrl_ff <= lwdata_ff; // RQ3
         end else if (cadr == tmrm_pkg::OFS_PACING) begin
            pacing_ff <= lwdata_ff; // RQ4
         end else if (cadr == tmrm_pkg::OFS_INT_HI) begin
            int_hi_ff <= lwdata_ff; // RQ5
         end else if (cadr == tmrm_pkg::OFS_INT_LO) begin
            int_lo_ff <= lwdata_ff; // RQ6
         end else if (cadr == tmrm_pkg::OFS_EXT1_HI) begin
            e1_hi_ff <= lwdata_ff; // RQ7
         end else if (cadr == tmrm_pkg::OFS_EXT1_HI_FRAC) begin
            e1_hif_ff <= lwdata_ff & tmrm_pkg::FRAC_USED; // RQ7
         end else if (cadr == tmrm_pkg::OFS_EXT1_LO) begin
            e1_lo_ff <= lwdata_ff; // RQ8
         end else if (cadr == tmrm_pkg::OFS_EXT1_LO_FRAC) begin
            e1_lof_ff <= lwdata_ff & tmrm_pkg::FRAC_USED; // RQ8
         end else if (cadr == tmrm_pkg::OFS_SPARE_A) begin
            spare_a_ff <= lwdata_ff; // RQ13
         end else if (cadr == tmrm_pkg::OFS_SPARE_B) begin
            spare_b_ff <= lwdata_ff; // RQ13
         end else if (cadr == tmrm_pkg::OFS_EXT2_HI) begin
            e2_hi_ff <= lwdata_ff; // RQ14
         end else if (cadr == tmrm_pkg::OFS_EXT2_LO) begin
            e2_lo_ff <= lwdata_ff; // RQ14
         end else if (cadr == tmrm_pkg::OFS_EXT2_HI_FRAC) begin
            e2_hif_ff <= lwdata_ff & tmrm_pkg::FRAC_USED; // RQ14
         end else if (cadr == tmrm_pkg::OFS_EXT2_LO_FRAC) begin
            e2_lof_ff <= lwdata_ff & tmrm_pkg::FRAC_USED; // RQ14
         end else if (cadr == tmrm_pkg::OFS_EXT1_CRIT) begin
            e1_crit_ff <= lwdata_ff; // RQ15
         end else if (cadr == tmrm_pkg::OFS_EXT2_CRIT) begin
            e2_crit_ff <= lwdata_ff; // RQ15
         end else if (cadr == tmrm_pkg::OFS_CHAN_MASK) begin
            mask_ff <= lwdata_ff & tmrm_pkg::MASK_USED; // RQ17
         end
      end
   end

   // ==========================================================
   // Core domain: measurement results and flags
   wire ext_rng = ctrl_ff[tmrm_pkg::CTRL_EXT_RANGE_BIT];
   wire [10:0] int_code = encode(int_temp_i, ext_rng); // RQ19
   wire [10:0] e1_code = ext1_fault_i ? tmrm_pkg::RST_TEMP : encode(ext1_temp_i, ext_rng);
   wire [7:0] fault_set = {5'h00, ext2_fault_i, ext1_fault_i, 1'b0} & {8{meas_valid_i}};
   wire fault_rd = rd_en && (cadr == tmrm_pkg::OFS_FAULT);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         int_res_ff <= tmrm_pkg::RST_TEMP; // RQ11
         e1_res_ff <= tmrm_pkg::RST_TEMP; // RQ10
         status_ff <= tmrm_pkg::RST_ZERO; // RQ12
         fault_ff <= tmrm_pkg::RST_ZERO; // RQ16
         oneshot_ff <= 1'b0;
      end else begin
         if (meas_valid_i) begin
            int_res_ff <= int_code; // RQ18
            e1_res_ff <= e1_code; // RQ18
            status_ff <= status_i; // RQ12
         end
         // A fault arriving with the clearing read survives it
         if (fault_rd) begin
            fault_ff <= fault_set; // RQ16
         end else begin
            fault_ff <= fault_ff | fault_set; // RQ16
         end
         oneshot_ff <= wr_en && (cadr == tmrm_pkg::OFS_ONESHOT); // RQ9
      end
   end

   // ==========================================================
   // Core domain: read data and answer toggle
   logic [7:0] rmux;

   always_comb begin
      rmux = tmrm_pkg::RST_ZERO; // RQ1
      if (cadr == tmrm_pkg::OFS_INT_TEMP) begin
         rmux = int_res_ff[10:3]; // RQ11
      end else if (cadr == tmrm_pkg::OFS_EXT1_TEMP) begin
         rmux = e1_res_ff[10:3]; // RQ10
      end else if (cadr == tmrm_pkg::OFS_EXT1_FRAC) begin
         rmux = {e1_res_ff[2:0], 5'h00}; // RQ18
      end else if (cadr == tmrm_pkg::OFS_STATUS) begin
         rmux = status_ff; // RQ12
      end else if (cadr == tmrm_pkg::OFS_CTRL) begin
         rmux = ctrl_ff; // RQ3
      end else if (cadr == tmrm_pkg::OFS_PACING) begin
         rmux = pacing_ff; // RQ4
      end else if (cadr == tmrm_pkg::OFS_INT_HI) begin
         rmux = int_hi_ff;
      end else if (cadr == tmrm_pkg::OFS_INT_LO) begin
         rmux = int_lo_ff;
      end else if (cadr == tmrm_pkg::OFS_EXT1_HI) begin
         rmux = e1_hi_ff;
      end else if (cadr == tmrm_pkg::OFS_EXT1_LO) begin
         rmux = e1_lo_ff;
      end else if (cadr == tmrm_pkg::OFS_EXT1_HI_FRAC) begin
         rmux = e1_hif_ff;
      end else if (cadr == tmrm_pkg::OFS_EXT1_LO_FRAC) begin
         rmux = e1_lof_ff;
      end else if (cadr == tmrm_pkg::OFS_SPARE_A) begin
         rmux = spare_a_ff;
      end else if (cadr == tmrm_pkg::OFS_SPARE_B) begin
         rmux = spare_b_ff;
      end else if (cadr == tmrm_pkg::OFS_EXT2_HI) begin
         rmux = e2_hi_ff;
      end else if (cadr == tmrm_pkg::OFS_EXT2_LO) begin
         rmux = e2_lo_ff;
      end else if (cadr == tmrm_pkg::OFS_EXT2_HI_FRAC) begin
         rmux = e2_hif_ff;
      end else if (cadr == tmrm_pkg::OFS_EXT2_LO_FRAC) begin
         rmux = e2_lof_ff;
      end else if (cadr == tmrm_pkg::OFS_EXT1_CRIT) begin
         rmux = e1_crit_ff;
      end else if (cadr == tmrm_pkg::OFS_EXT2_CRIT) begin
         rmux = e2_crit_ff;
      end else if (cadr == tmrm_pkg::OFS_FAULT) begin
         rmux = fault_ff & tmrm_pkg::FAULT_USED; // RQ1
      end else if (cadr == tmrm_pkg::OFS_CHAN_MASK) begin
         rmux = mask_ff;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ack_tgl_ff <= 1'b0;
         crdata_ff <= tmrm_pkg::RST_ZERO;
      end else if (acc) begin
         ack_tgl_ff <= ~ack_tgl_ff; // RQ2
         crdata_ff <= lwr_ff ? tmrm_pkg::RST_ZERO : rmux; // RQ20
      end
   end

   // ==========================================================
   // Outputs to the conversion engine
   assign ctrl_o = ctrl_ff;
   assign pacing_o = pacing_ff;
   assign ext_range_o = ext_rng; // RQ19
   assign oneshot_o = oneshot_ff; // RQ9
   assign int_hi_lim_o = int_hi_ff;
   assign int_lo_lim_o = int_lo_ff;
   assign ext1_hi_lim_o = {e1_hi_ff, e1_hif_ff[7:5]};
   assign ext1_lo_lim_o = {e1_lo_ff, e1_lof_ff[7:5]};
   assign ext2_hi_lim_o = {e2_hi_ff, e2_hif_ff[7:5]};
   assign ext2_lo_lim_o = {e2_lo_ff, e2_lof_ff[7:5]};
   assign ext1_crit_o = e1_crit_ff;
   assign ext2_crit_o = e2_crit_ff;
   assign chan_mask_o = mask_ff;
endmodule

/* File: testbench/tmrm_regs_assertions.sv */
module tmrm_regs_checker (
   input logic core_clk_i,
   input logic rst_i,
   input logic lnk_clk_i,
   input logic lnk_req_i,
   input logic lnk_busy_o,
   input logic lnk_ack_o,
   input logic [7:0] ctrl_o,
   input logic [7:0] pacing_o,
   input logic ext_range_o,
   input logic oneshot_o,
   input logic [7:0] int_hi_lim_o,
   input logic [10:0] ext1_hi_lim_o,
   input logic [10:0] ext2_hi_lim_o,
   input logic [7:0] ext1_crit_o,
   input logic [7:0] ext2_crit_o,
   input logic [7:0] chan_mask_o
);
   // ==========
   // Link handshake
   property p_ack_pulse;
      @(posedge lnk_clk_i) disable iff (rst_i) lnk_ack_o |=> !lnk_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack width");
   property p_ack_bound;
      @(posedge lnk_clk_i) disable iff (rst_i)
         lnk_req_i && !lnk_busy_o |=> lnk_busy_o ##[3:5] lnk_ack_o;
   endproperty
   a_ack_bound: assert property (p_ack_bound) else $error("ack late");
   property p_busy_hold;
      @(posedge lnk_clk_i) disable iff (rst_i) lnk_ack_o |-> !lnk_busy_o && $past(lnk_busy_o);
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy span");
   // ==========
   // Core outputs
   property p_rst_ctrl;
      @(posedge core_clk_i) disable iff (rst_i)
         $fell(rst_i) |-> ctrl_o == 8'h80 && pacing_o == 8'h06;
   endproperty
   a_rst_ctrl: assert property (p_rst_ctrl) else $error("ctrl reset");
   property p_rst_lims;
      @(posedge core_clk_i) disable iff (rst_i) $fell(rst_i) |-> int_hi_lim_o == 8'h55
         && ext1_hi_lim_o == 11'h2A8 && ext2_hi_lim_o == 11'h2A8 && ext1_crit_o == 8'h55
         && ext2_crit_o == 8'h55;
   endproperty
   a_rst_lims: assert property (p_rst_lims) else $error("limit reset");
   property p_os_pulse;
      @(posedge core_clk_i) disable iff (rst_i) oneshot_o |=> !oneshot_o;
   endproperty
   a_os_pulse: assert property (p_os_pulse) else $error("oneshot width");
   property p_range;
      @(posedge core_clk_i) disable iff (rst_i) ext_range_o == ctrl_o[2];
   endproperty
   a_range: assert property (p_range) else $error("range bit");
   property p_mask_used;
      @(posedge core_clk_i) disable iff (rst_i) chan_mask_o[7:3] == 5'h00;
   endproperty
   a_mask_used: assert property (p_mask_used) else $error("mask bits");
   c_take: cover property (@(posedge lnk_clk_i) lnk_req_i && !lnk_busy_o);
   c_oneshot: cover property (@(posedge core_clk_i) oneshot_o);
   c_range: cover property (@(posedge core_clk_i) $rose(ext_range_o));
endmodule

bind tmrm_regs tmrm_regs_checker u_tmrm_regs_checker (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .lnk_clk_i(lnk_clk_i), .lnk_req_i(lnk_req_i),
   .lnk_busy_o(lnk_busy_o), .lnk_ack_o(lnk_ack_o), .ctrl_o(ctrl_o), .pacing_o(pacing_o),
   .ext_range_o(ext_range_o), .oneshot_o(oneshot_o), .int_hi_lim_o(int_hi_lim_o),
   .ext1_hi_lim_o(ext1_hi_lim_o), .ext2_hi_lim_o(ext2_hi_lim_o),
   .ext1_crit_o(ext1_crit_o), .ext2_crit_o(ext2_crit_o), .chan_mask_o(chan_mask_o)
);

/* File: testbench/tmrm_host_model.sv */
module tmrm_host_model (
   input wire logic lnk_clk_i,
   input wire logic lnk_busy_i,
   input wire logic lnk_ack_i,
   input wire logic [7:0] lnk_rdata_i,
   output logic lnk_req_o,
   output logic lnk_wr_o,
   output logic [7:0] lnk_addr_o,
   output logic [7:0] lnk_wdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      lnk_req_o = 1'b0;
      lnk_wr_o = 1'b0;
      lnk_addr_o = 8'hA5;
      lnk_wdata_o = 8'h5A;
   end
   // ==========
   // One register access, random idle gap first
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] rd, output logic ok);
      int n;
      ok = 1'b0;
      rd = 8'h00;
      repeat ($urandom_range(1, 4)) @(negedge lnk_clk_i);
      for (n = 0; n < 20 && lnk_busy_i !== 1'b0; n++) @(negedge lnk_clk_i);
      lnk_req_o = 1'b1;
      lnk_wr_o = w;
      lnk_addr_o = a;
      lnk_wdata_o = d;
      @(negedge lnk_clk_i);
      lnk_req_o = 1'b0;
      lnk_wr_o = ~w;
      lnk_addr_o = ~a;
      lnk_wdata_o = ~d;
      for (n = 0; n < 20 && ok !== 1'b1; n++) begin
         @(posedge lnk_clk_i);
         ok = lnk_ack_i;
         rd = lnk_rdata_i;
      end
   endtask
endmodule

/* File: testbench/tmrm_regs_tb_top.sv */
module tmrm_regs_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic lnk_clk = 1'b0;
   logic rst = 1'b1;
   logic mv = 1'b0;
   logic [1:0] flt = 2'h0;
   logic [11:0] t_int = 12'h000;
   logic [11:0] t_ext = 12'h000;
   logic [7:0] st = 8'h00;
   logic req, wr, busy, ack, rng_o, os_o;
   logic [7:0] addr, wdata, rdata, ctrl_o, pace_o, ihi_o, ilo_o, c1_o, c2_o, mask_o;
   logic [10:0] e1hi_o, e1lo_o, e2hi_o, e2lo_o;
   logic [7:0] shd [0:255];
   logic [7:0] rd_got = 8'h00;
   logic [7:0] ro [5] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h1B};
   int mismatches = 0;
   int n_tests = 0;
   int n_os = 0;
   int exp_os = 0;

   always #2.5 core_clk = ~core_clk;
   always #16 lnk_clk = ~lnk_clk;
   always @(posedge core_clk) if (os_o === 1'b1) n_os++;

   tmrm_regs u_tmrm_regs (
      .core_clk_i(core_clk), .rst_i(rst), .lnk_clk_i(lnk_clk), .lnk_req_i(req),
      .lnk_wr_i(wr), .lnk_addr_i(addr), .lnk_wdata_i(wdata), .lnk_busy_o(busy),
      .lnk_ack_o(ack), .lnk_rdata_o(rdata), .meas_valid_i(mv), .int_temp_i(t_int),
      .ext1_temp_i(t_ext), .ext1_fault_i(flt[0]), .ext2_fault_i(flt[1]), .status_i(st),
      .ctrl_o(ctrl_o), .pacing_o(pace_o), .ext_range_o(rng_o), .oneshot_o(os_o),
      .int_hi_lim_o(ihi_o), .int_lo_lim_o(ilo_o), .ext1_hi_lim_o(e1hi_o),
      .ext1_lo_lim_o(e1lo_o), .ext2_hi_lim_o(e2hi_o), .ext2_lo_lim_o(e2lo_o),
      .ext1_crit_o(c1_o), .ext2_crit_o(c2_o), .chan_mask_o(mask_o)
   );
   tmrm_host_model u_tmrm_host_model (
      .lnk_clk_i(lnk_clk), .lnk_busy_i(busy), .lnk_ack_i(ack), .lnk_rdata_i(rdata),
      .lnk_req_o(req), .lnk_wr_o(wr), .lnk_addr_o(addr), .lnk_wdata_o(wdata)
   );

   // ==========
   // Checking helpers
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [10:0] e, input logic [10:0] s);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   function automatic logic [7:0] canon(input logic [7:0] a);
      return (a >= 8'h09 && a <= 8'h0E) ? a - 8'h06 : a;
   endfunction
   function automatic logic [10:0] enc(input logic [11:0] t, input logic x);
      logic signed [13:0] v;
      v = $signed({{2{t[11]}}, t}) + (x ? 14'sh200 : 14'sh000);
      if (v < 0) return 11'h000;
      if (v > (x ? 14'sh7FF : 14'sh3FF)) return x ? 11'h7FF : 11'h3FF;
      return v[10:0];
   endfunction
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic ok;
      u_tmrm_host_model.xfer(w, a, d, rd_got, ok);
      if (ok !== 1'b1) begin
         mismatches++;
         summarize();
      end
   endtask
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] c;
      logic [7:0] m;
      c = canon(a);
      m = (c == 8'h13 || c == 8'h14 || c == 8'h17 || c == 8'h18) ? 8'hE0 : 8'hFF;
      xfer(1'b1, a, d);
      if (a == 8'h0F) exp_os++;
      if ((c >= 8'h03 && c <= 8'h08) || (c >= 8'h11 && c <= 8'h1A))
         shd[c] = d & m;
      if (c == 8'h1F) shd[c] = d & 8'h07;
   endtask
   task automatic rd8(input logic [7:0] a);
      xfer(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), 11'(shd[canon(a)]), 11'(rd_got));
      if (a == 8'h1B) shd[a] = 8'h00;
   endtask
   task automatic meas(input logic [11:0] ti, input logic [11:0] te, input logic [1:0] f);
      logic [10:0] e;
      @(negedge core_clk);
      mv = 1'b1;
      t_int = ti;
      t_ext = te;
      flt = f;
      st = 8'($urandom);
      @(negedge core_clk);
      mv = 1'b0;
      e = f[0] ? 11'h000 : enc(te, shd[3][2]);
      shd[0] = 8'(enc(ti, shd[3][2]) >> 3);
      shd[1] = e[10:3];
      shd[8'h10] = {e[2:0], 5'h00};
      shd[2] = st;
      shd[8'h1B] = shd[8'h1B] | {5'h00, f, 1'b0};
   endtask
   task automatic chk_outs();
      chk("ctrl", 11'(shd[3]), 11'(ctrl_o));
      chk("pacing", 11'(shd[4]), 11'(pace_o));
      chk("range", 11'(shd[3][2]), 11'(rng_o));
      chk("int hi", 11'(shd[5]), 11'(ihi_o));
      chk("int lo", 11'(shd[6]), 11'(ilo_o));
      chk("ext1 hi", {shd[7], shd[8'h13][7:5]}, e1hi_o);
      chk("ext1 lo", {shd[8], shd[8'h14][7:5]}, e1lo_o);
      chk("ext2 hi", {shd[8'h15], shd[8'h17][7:5]}, e2hi_o);
      chk("ext2 lo", {shd[8'h16], shd[8'h18][7:5]}, e2lo_o);
      chk("crit1", 11'(shd[8'h19]), 11'(c1_o));
      chk("crit2", 11'(shd[8'h1A]), 11'(c2_o));
      chk("mask", 11'(shd[8'h1F]), 11'(mask_o));
   endtask

   // ==========
   // Main sequence
   initial begin
      int i;
      logic [7:0] a;
      void'($urandom(98494));
      for (i = 0; i < 256; i++) shd[i] = 8'h00;
      shd[3] = 8'h80;
      shd[4] = 8'h06;
      shd[5] = 8'h55;
      shd[7] = 8'h55;
      shd[8'h15] = 8'h55;
      shd[8'h19] = 8'h55;
      shd[8'h1A] = 8'h55;
      repeat (4) @(posedge lnk_clk);
      @(negedge core_clk);
      rst = 1'b0;
      repeat (3) @(posedge lnk_clk);
      for (i = 0; i < 34; i++) rd8(8'(i));
      chk_outs();
      for (a = 8'h03; a <= 8'h08; a++) begin
         wr8(a, 8'($urandom));
         rd8(a + 8'h06);
         wr8(a + 8'h06, 8'($urandom));
         rd8(a);
      end
      foreach (ro[j]) begin
         wr8(ro[j], 8'hFF);
         rd8(ro[j]);
      end
      repeat (80) begin
         a = 8'($urandom_range(0, 33));
         if ($urandom_range(0, 1)) wr8(a, 8'($urandom));
         else rd8(a);
      end
      chk_outs();
      for (i = 0; i < 10; i++) begin
         wr8(8'h03, 8'($urandom));
         meas(i == 0 ? 12'h800 : 12'($urandom), i == 1 ? 12'h7FF : 12'($urandom), 2'(i));
         rd8(8'h00);
         rd8(8'h01);
         rd8(8'h10);
         rd8(8'h02);
         rd8(8'h1B);
         rd8(8'h1B);
      end
      repeat (10) @(posedge core_clk);
      chk("oneshot count", 11'(exp_os), 11'(n_os));
      chk_outs();
      summarize();
   end
   initial begin
      #400us;
      mismatches++;
      summarize();
   end
endmodule
